/* File: rtl/ffs_sequencer.sv */
// fault detection and operating-state sequencer for a flyback controller
// What this block does
// - every fault leads to lockout reset, restart
// - feedback over 4.6V thrice stops, fault bias
// - lockout threshold after fault returns to start
// - line current hysteresis run 225uA, stop 80uA
// - on-time ends at peak, every cycle
// - sense over 1.5V thrice triggers restart
// - first four cycles minimum peak; 4us short check
// - open sense pull-up fires thrice over-level fault
// - over-temperature starts a lockout reset cycle
// - still hot at lockout end repeats protection
// - lost feedback stops switching and restarts
// - start-up source on below turn-on threshold
// - above turn-on, source off, switching begins
// - constant current while output below regulation
// - constant voltage while load below current limit
// - peak above 0.55 max keeps run state
// - light constant voltage waits between cycles
// - below turn-off stop, start bias, source on
// - fault: fault bias, then start bias at turn-off
// - persisting fault repeats the sequence
`timescale 1ns/1ps
`default_nettype none
module ffs_sequencer (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// switching cycle events
	input wire logic on_start,
	input wire logic cyc_end,
	// comparator results
	input wire ffs_pkg::ffs_sense_s sense,
	input wire ffs_pkg::ffs_bias_s bias_in,
	input wire ffs_pkg::ffs_reg_s reg_in,
	// power stage control
	output logic gate_en_ff,
	output logic gate_off_ff,
	output logic startup_src_en_ff,
	output ffs_pkg::ffs_bias_e bias_sel_ff,
	output logic peak_min_cap_ff,
	output logic constant_current_mode_ff,
	output logic constant_voltage_mode_ff,
	output ffs_pkg::ffs_state_e state_ff,
	output logic fault_evt_ff
);
	ffs_pkg::ffs_state_e nxt_state;
	logic line_ok_ff;
	logic nxt_line_ok;
	logic [2:0] start_cnt_ff;
	logic first_cyc_ff;
	logic on_ff;
	logic [ffs_pkg::SHORT_W-1:0] on_cnt_ff;
	logic short_hit;
	logic fb_hit;
	logic cs_hit;
	logic in_lock;
	logic running;
	logic fault_now;
	logic ctr_clr;

	// ==========================================
	// helpers
	function automatic logic is_switching(ffs_pkg::ffs_state_e s);
		return (s == ffs_pkg::ST_RUN) || (s == ffs_pkg::ST_WAIT);
	endfunction

	assign in_lock = (state_ff == ffs_pkg::ST_LOCK) ||
		(state_ff == ffs_pkg::ST_FAULT);
	assign running = is_switching(state_ff);
	assign ctr_clr = in_lock || (state_ff == ffs_pkg::ST_START);

	// ==========================================
	// consecutive-cycle fault counters
	ffs_run3 u_fb (
		.clk(clk),
		.sys_rst(sys_rst),
		.cyc_end(cyc_end && running),
		.cond(sense.fb_over),
		.clr(ctr_clr),
		.hit(fb_hit)
	);

	ffs_run3 u_cs (
		.clk(clk),
		.sys_rst(sys_rst),
		.cyc_end(cyc_end && running),
		.cond(sense.cs_over),
		.clr(ctr_clr),
		.hit(cs_hit)
	);

	// ==========================================
	// line sense hysteresis
	always_comb begin
		nxt_line_ok = line_ok_ff;
		if (on_ff && sense.line_run) begin
			nxt_line_ok = 1'b1;
		end else if (on_ff && sense.line_stop) begin
			nxt_line_ok = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_ok_ff <= 1'b0;
		end else if (in_lock) begin
			line_ok_ff <= line_ok_ff;
		end else begin
			line_ok_ff <= nxt_line_ok;
		end
	end

	// ==========================================
	// on-time tracking and short check
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			on_ff <= 1'b0;
		end else if (!running) begin
			on_ff <= 1'b0;
		end else if (on_start) begin
			on_ff <= 1'b1;
		end else if (sense.cs_peak_hit || cyc_end || short_hit) begin
			on_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			on_cnt_ff <= '0;
		end else if (on_start || !on_ff) begin
			on_cnt_ff <= '0;
		end else if (on_cnt_ff != ffs_pkg::SHORT_LIM) begin
			on_cnt_ff <= on_cnt_ff + 1'b1;
		end
	end

	assign short_hit = on_ff && first_cyc_ff && !sense.cs_min_hit &&
		(on_cnt_ff == ffs_pkg::SHORT_LIM - 1'b1);

	// ==========================================
	// start-up cycle count
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_cnt_ff <= 3'h0;
		end else if (!running) begin
			start_cnt_ff <= 3'h0;
		end else if (cyc_end && start_cnt_ff != ffs_pkg::START_CYCLES) begin
			start_cnt_ff <= start_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			first_cyc_ff <= 1'b1;
		end else if (!running) begin
			first_cyc_ff <= 1'b1;
		end else if (cyc_end) begin
			first_cyc_ff <= 1'b0;
		end
	end

	// ==========================================
	// fault gathering
	assign fault_now = running && (fb_hit || cs_hit || short_hit ||
		sense.over_temp || sense.fb_lost ||
		(on_ff && !nxt_line_ok));

	// ==========================================
	// state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ffs_pkg::ST_START: begin
				if (bias_in.vdd_on) begin
					nxt_state = ffs_pkg::ST_RUN;
				end
			end
			ffs_pkg::ST_RUN: begin
				if (fault_now) begin
					nxt_state = ffs_pkg::ST_FAULT;
				end else if (bias_in.vdd_off) begin
					nxt_state = ffs_pkg::ST_START;
				end else if (cyc_end && !reg_in.peak_high &&
					reg_in.load_below_limit && !reg_in.out_low) begin
					nxt_state = ffs_pkg::ST_WAIT;
				end
			end
			ffs_pkg::ST_WAIT: begin
				if (fault_now) begin
					nxt_state = ffs_pkg::ST_FAULT;
				end else if (bias_in.vdd_off) begin
					nxt_state = ffs_pkg::ST_START;
				end else if (on_start || reg_in.peak_high) begin
					nxt_state = ffs_pkg::ST_RUN;
				end
			end
			ffs_pkg::ST_FAULT: begin
				if (bias_in.vdd_off) begin
					nxt_state = ffs_pkg::ST_LOCK;
				end
			end
			ffs_pkg::ST_LOCK: begin
				if (bias_in.vdd_on) begin
					if (sense.over_temp) begin
						nxt_state = ffs_pkg::ST_FAULT;
					end else begin
						nxt_state = ffs_pkg::ST_RUN;
					end
				end
			end
			default: begin
				nxt_state = ffs_pkg::ST_START;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= ffs_pkg::ST_START;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================
	// power stage outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gate_en_ff <= 1'b0;
		end else begin
			gate_en_ff <= is_switching(nxt_state);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			startup_src_en_ff <= 1'b1;
		end else begin
			startup_src_en_ff <= (nxt_state == ffs_pkg::ST_START) ||
				(nxt_state == ffs_pkg::ST_LOCK);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bias_sel_ff <= ffs_pkg::BIAS_START;
		end else begin
			case (nxt_state)
				ffs_pkg::ST_RUN: bias_sel_ff <= ffs_pkg::BIAS_RUN;
				ffs_pkg::ST_WAIT: bias_sel_ff <= ffs_pkg::BIAS_WAIT;
				ffs_pkg::ST_FAULT: bias_sel_ff <= ffs_pkg::BIAS_FAULT;
				default: bias_sel_ff <= ffs_pkg::BIAS_START;
			endcase
		end
	end

	// ==========================================
	// cycle and fault events
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gate_off_ff <= 1'b0;
		end else begin
			gate_off_ff <= on_ff && (sense.cs_peak_hit || short_hit);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_evt_ff <= 1'b0;
		end else begin
			fault_evt_ff <= (nxt_state == ffs_pkg::ST_FAULT) &&
				(state_ff != ffs_pkg::ST_FAULT);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			peak_min_cap_ff <= 1'b1;
		end else begin
			peak_min_cap_ff <= !running ||
				(start_cnt_ff != ffs_pkg::START_CYCLES);
		end
	end

	// ==========================================
	// regulation mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			constant_current_mode_ff <= 1'b0;
			constant_voltage_mode_ff <= 1'b0;
		end else if (in_lock) begin
			constant_current_mode_ff <= 1'b0;
			constant_voltage_mode_ff <= 1'b0;
		end else begin
			constant_current_mode_ff <= running && reg_in.out_low;
			constant_voltage_mode_ff <= running && !reg_in.out_low &&
				reg_in.load_below_limit;
		end
	end
endmodule // ffs_sequencer
`default_nettype wire

/* File: rtl/ffs_pkg.sv */
// package: states, bias levels, counts and carriers for the fault sequencer
package ffs_pkg;

	// ==========================================
	// timing
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned SHORT_US = 4;
	localparam int unsigned SHORT_CYC = SHORT_US * CLK_MHZ;
	localparam int unsigned SHORT_W = 12;
	localparam logic [SHORT_W-1:0] SHORT_LIM = SHORT_W'(SHORT_CYC);

	// ==========================================
	// counts
	localparam logic [1:0] FAULT_RUN_LEN = 2'h3;
	localparam logic [2:0] START_CYCLES = 3'h4;
	localparam logic [1:0] CNT_RST = 2'h0;

	// ==========================================
	// states
	typedef enum logic [4:0] {
		ST_START = 5'h01,
		ST_RUN = 5'h02,
		ST_WAIT = 5'h04,
		ST_FAULT = 5'h08,
		ST_LOCK = 5'h10
	} ffs_state_e;

	typedef enum logic [1:0] {
		BIAS_START = 2'h0,
		BIAS_RUN = 2'h1,
		BIAS_WAIT = 2'h2,
		BIAS_FAULT = 2'h3
	} ffs_bias_e;

	// ==========================================
	// carriers
	typedef struct packed {
		logic fb_over;
		logic fb_lost;
		logic cs_over;
		logic cs_min_hit;
		logic cs_peak_hit;
		logic line_run;
		logic line_stop;
		logic over_temp;
	} ffs_sense_s;

	typedef struct packed {
		logic vdd_on;
		logic vdd_off;
	} ffs_bias_s;

	typedef struct packed {
		logic out_low;
		logic load_below_limit;
		logic peak_high;
	} ffs_reg_s;

endpackage

/* File: rtl/ffs_run3.sv */
// three-in-a-row cycle counter for one fault condition
`timescale 1ns/1ps
`default_nettype none
module ffs_run3 (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// cycle and condition
	input wire logic cyc_end,
	input wire logic cond,
	input wire logic clr,
	// result
	output logic hit
);
	logic [1:0] cnt_ff;

	// ==========================================
	// counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= ffs_pkg::CNT_RST;
		end else if (clr) begin
			cnt_ff <= ffs_pkg::CNT_RST;
		end else if (cyc_end) begin
			if (!cond) begin
				cnt_ff <= ffs_pkg::CNT_RST;
			end else if (cnt_ff != ffs_pkg::FAULT_RUN_LEN) begin
				cnt_ff <= cnt_ff + 2'h1;
			end
		end
	end

	assign hit = cyc_end && cond && !clr &&
		(cnt_ff == ffs_pkg::FAULT_RUN_LEN - 2'h1);
endmodule // ffs_run3
`default_nettype wire

/* File: testbench/ffs_sequencer_properties.sv */
// checker: state and output relations of the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module ffs_sequencer_properties (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// observed ports
	input wire ffs_pkg::ffs_sense_s sense,
	input wire ffs_pkg::ffs_bias_s bias_in,
	input wire logic gate_en_ff,
	input wire logic startup_src_en_ff,
	input wire ffs_pkg::ffs_bias_e bias_sel_ff,
	input wire ffs_pkg::ffs_state_e state_ff,
	input wire logic fault_evt_ff
);
	// ========
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	start_src_a: assert property (state_ff == ffs_pkg::ST_START
		|-> startup_src_en_ff && !gate_en_ff) else $error("start bad");
	start_on_a: assert property (state_ff == ffs_pkg::ST_START
		&& bias_in.vdd_on |=> state_ff == ffs_pkg::ST_RUN && gate_en_ff
		&& !startup_src_en_ff) else $error("no switching at turn-on");
	fault_entry_a: assert property ($rose(state_ff == ffs_pkg::ST_FAULT)
		|-> fault_evt_ff && bias_sel_ff == ffs_pkg::BIAS_FAULT
		&& !gate_en_ff) else $error("fault entry bad");
	fault_hold_a: assert property (state_ff == ffs_pkg::ST_FAULT
		&& !bias_in.vdd_off |=> state_ff == ffs_pkg::ST_FAULT)
		else $error("fault left early");
	fault_lock_a: assert property (state_ff == ffs_pkg::ST_FAULT
		&& bias_in.vdd_off |=> state_ff == ffs_pkg::ST_LOCK)
		else $error("no lockout");
	lock_bias_a: assert property (state_ff == ffs_pkg::ST_LOCK
		|-> startup_src_en_ff && bias_sel_ff == ffs_pkg::BIAS_START)
		else $error("lockout bias bad");
	lock_hot_a: assert property (state_ff == ffs_pkg::ST_LOCK
		&& bias_in.vdd_on && sense.over_temp
		|=> state_ff == ffs_pkg::ST_FAULT) else $error("hot restart");
	lock_exit_a: assert property (state_ff == ffs_pkg::ST_LOCK
		&& bias_in.vdd_on && !sense.over_temp
		|=> state_ff == ffs_pkg::ST_RUN) else $error("no restart");
endmodule // ffs_sequencer_properties
bind ffs_sequencer ffs_sequencer_properties u_prop (.clk, .sys_rst,
	.sense, .bias_in, .gate_en_ff, .startup_src_en_ff, .bias_sel_ff,
	.state_ff, .fault_evt_ff);
`default_nettype wire

/* File: testbench/ffs_stage_model.sv */
// partner: bias capacitor charged by the start-up source
`timescale 1ns/1ps
`default_nettype none
module ffs_stage_model #(
	parameter int TOP = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// controls
	input wire logic src_en,
	input wire ffs_pkg::ffs_bias_e bias_sel,
	// thresholds
	output ffs_pkg::ffs_bias_s bias_out
);
	int lvl;
	// charges under the source, drains under fault bias
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			lvl <= 0;
		else if (src_en && lvl < TOP)
			lvl <= lvl + 1;
		else if (bias_sel == ffs_pkg::BIAS_FAULT && lvl > 0)
			lvl <= lvl - 1;
	end
	assign bias_out = {lvl >= TOP, lvl == 0};
endmodule // ffs_stage_model
`default_nettype wire

/* File: testbench/ffs_sequencer_tb_top.sv */
// bench: start-up, fault and restart sequences of the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module ffs_sequencer_tb_top;
	logic clk, sys_rst, on_start, cyc_end;
	logic gate_en_ff, gate_off_ff, startup_src_en_ff, peak_min_cap_ff;
	logic constant_current_mode_ff, constant_voltage_mode_ff, fault_evt_ff;
	ffs_pkg::ffs_sense_s sense;
	ffs_pkg::ffs_bias_s bias_in;
	ffs_pkg::ffs_reg_s reg_in;
	ffs_pkg::ffs_bias_e bias_sel_ff;
	ffs_pkg::ffs_state_e state_ff;
	int fails = 0;
	int cmp_count = 0;
	int ticks = 0;
	ffs_sequencer u_dut (.clk, .sys_rst, .on_start, .cyc_end, .sense,
		.bias_in, .reg_in, .gate_en_ff, .gate_off_ff, .startup_src_en_ff,
		.bias_sel_ff, .peak_min_cap_ff, .constant_current_mode_ff,
		.constant_voltage_mode_ff, .state_ff, .fault_evt_ff);
	ffs_stage_model u_stage (.clk, .sys_rst, .src_en(startup_src_en_ff),
		.bias_sel(bias_sel_ff), .bias_out(bias_in));
	// ========
	// clock and time limit
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			fails++;
			close_out();
		end
	end
	// ========
	// helpers
	task automatic close_out();
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wait_st(ffs_pkg::ffs_state_e s, int lim);
		int n;
		n = 0;
		while (state_ff !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("state", 8'(s), 8'(state_ff));
	endtask
	task automatic cyc(logic fb, logic cs);
		sense.fb_over = fb;
		sense.cs_over = cs;
		on_start = 1;
		@(negedge clk);
		on_start = 0;
		cyc_end = 1;
		@(negedge clk);
		cyc_end = 0;
		@(negedge clk);
	endtask
	// ========
	// scenarios
	task automatic t_boot();
		chk("src", 8'h01, 8'(startup_src_en_ff));
		chk("cap", 8'h01, 8'(peak_min_cap_ff));
		sys_rst = 0;
		wait_st(ffs_pkg::ST_RUN, 200);
		chk("gate", 8'h01, 8'(gate_en_ff));
		chk("bias", 8'(ffs_pkg::BIAS_RUN), 8'(bias_sel_ff));
	endtask
	task automatic t_modes();
		reg_in = 3'h2;
		cyc(0, 0);
		chk("wait", 8'(ffs_pkg::ST_WAIT), 8'(state_ff));
		chk("bias", 8'(ffs_pkg::BIAS_WAIT), 8'(bias_sel_ff));
		chk("cv", 8'h01, 8'(constant_voltage_mode_ff));
		reg_in = 3'h3;
		@(negedge clk);
		@(negedge clk);
		chk("run", 8'(ffs_pkg::ST_RUN), 8'(state_ff));
		reg_in = 3'h4;
		cyc(0, 0);
		chk("cc", 8'h01, 8'(constant_current_mode_ff));
	endtask
	task automatic t_peak();
		on_start = 1;
		@(negedge clk);
		on_start = 0;
		sense.cs_peak_hit = 1;
		@(negedge clk);
		chk("off", 8'h01, 8'(gate_off_ff));
		sense.cs_peak_hit = 0;
		@(negedge clk);
		chk("off", 8'h00, 8'(gate_off_ff));
	endtask
	task automatic t_fault(logic fb, logic cs);
		cyc(fb, cs);
		cyc(fb, cs);
		cyc(0, 0);
		cyc(fb, cs);
		cyc(fb, cs);
		chk("cap", 8'h00, 8'(peak_min_cap_ff));
		chk("miss", 8'(ffs_pkg::ST_RUN), 8'(state_ff));
		cyc(fb, cs);
		chk("fault", 8'(ffs_pkg::ST_FAULT), 8'(state_ff));
		chk("bias", 8'(ffs_pkg::BIAS_FAULT), 8'(bias_sel_ff));
		wait_st(ffs_pkg::ST_LOCK, 200);
		wait_st(ffs_pkg::ST_RUN, 200);
		sense.fb_over = 0;
		sense.cs_over = 0;
	endtask
	task automatic t_hot();
		sense.over_temp = 1;
		wait_st(ffs_pkg::ST_FAULT, 20);
		chk("evt", 8'h01, 8'(fault_evt_ff));
		wait_st(ffs_pkg::ST_LOCK, 200);
		wait_st(ffs_pkg::ST_FAULT, 200);
		chk("evt", 8'h01, 8'(fault_evt_ff));
		sense.over_temp = 0;
		wait_st(ffs_pkg::ST_RUN, 400);
	endtask
	task automatic t_lost();
		sense.fb_lost = 1;
		wait_st(ffs_pkg::ST_FAULT, 4);
		chk("gate", 8'h00, 8'(gate_en_ff));
		sense.fb_lost = 0;
		wait_st(ffs_pkg::ST_LOCK, 200);
		wait_st(ffs_pkg::ST_RUN, 200);
	endtask
	task automatic t_line();
		sense.line_run = 0;
		cyc(0, 0);
		chk("hyst", 8'(ffs_pkg::ST_RUN), 8'(state_ff));
		sense.line_stop = 1;
		on_start = 1;
		@(negedge clk);
		on_start = 0;
		wait_st(ffs_pkg::ST_FAULT, 4);
		sense.line_run = 1;
		sense.line_stop = 0;
		wait_st(ffs_pkg::ST_LOCK, 200);
		wait_st(ffs_pkg::ST_RUN, 200);
	endtask
	task automatic t_short();
		sense.cs_min_hit = 0;
		on_start = 1;
		@(negedge clk);
		on_start = 0;
		repeat (780) @(negedge clk);
		chk("early", 8'(ffs_pkg::ST_RUN), 8'(state_ff));
		wait_st(ffs_pkg::ST_FAULT, 60);
	endtask
	// ========
	// main sequence
	initial begin
		sys_rst = 1;
		on_start = 0;
		cyc_end = 0;
		sense = '0;
		sense.cs_min_hit = 1;
		sense.line_run = 1;
		reg_in = '0;
		repeat (16) @(negedge clk);
		t_boot();
		t_modes();
		reg_in = '0;
		t_peak();
		t_fault(1, 0);
		t_fault(0, 1);
		t_hot();
		t_lost();
		t_line();
		t_short();
		close_out();
	end
endmodule // ffs_sequencer_tb_top
`default_nettype wire
